//--- bench/msg_sender.sv
// Purpose: Sending thread model that issues buffer write messages.
// Assumes: Caller picks legal payload sizes and modes.
// Notes:   Beat data is scrambled once the last beat is taken.
`timescale 1ns/100ps
`default_nettype none
module msg_sender
  import vbw_pkg::*;
(
  // Clock and flow control
  input  wire logic             clk,
  input  wire logic             msgReady,
  input  wire logic             busy,
  // Message output
  output var  logic             hdrValid,
  output var  header_type       hdr,
  output var  logic             beatValid,
  output var  logic             beatLast,
  output var  logic [ROW_W-1:0] beatData
);
  // Payload rows, filled by the bench before each send
  logic [ROW_W-1:0] pay [6];

  // ----------------------------------------
  // Quiet lines at time zero
  // ----------------------------------------
  initial
  begin
    hdrValid  = 1'b0;
    hdr       = '0;
    beatValid = 1'b0;
    beatLast  = 1'b0;
    beatData  = '0;
  end

  // ----------------------------------------
  // One whole message: header, then n beats
  // ----------------------------------------
  // Sizes: interleave whole two-row units, transpose whole 3-row groups
  // Transpose only used with transposed read enable clear
  task automatic send(input header_type h, input int n);
    hdr      <= h;
    hdrValid <= 1'b1;
    do @(posedge clk); while (busy !== 1'b0);
    hdrValid <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      beatValid <= 1'b1;
      beatLast  <= (i == n - 1);
      beatData  <= pay[i];
      do @(posedge clk); while (!(busy === 1'b1 && msgReady === 1'b1));
    end
    beatValid <= 1'b0;
    beatLast  <= 1'b0;
    beatData  <= ~pay[n-1]; // Stale data must not look valid
    do @(posedge clk); while (busy !== 1'b0);
    @(posedge clk); // Lets the bench capture the final outputs
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Purpose: Self-checking bench for the buffer write unpacker.
// Assumes: Sender model drives all message inputs.
// Notes:   Buffer writes and writebacks are queued and then judged.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import vbw_pkg::*;
;
  logic             clk;
  logic             srst;
  logic             hdrValid;
  header_type       hdr;
  logic             beatValid;
  logic             beatLast;
  logic [ROW_W-1:0] beatData;
  logic             msgReady;
  logic             wrValid;
  bufwrite_type     wr;
  logic             wbValid;
  logic [ROW_W-1:0] wbData;
  logic             busy;
  int               failures = 0;
  int               checks = 0;
  int               busyCnt = 0;
  int               holdCnt = 0;
  bufwrite_type     wq [$];
  logic [ROW_W-1:0] bq [$];

  vertex_buffer_write_unpack i_dut (.clk(clk), .srst(srst), .hdrValid(hdrValid),
    .hdr(hdr), .beatValid(beatValid), .beatLast(beatLast), .beatData(beatData),
    .msgReady(msgReady), .wrValid(wrValid), .wr(wr), .wbValid(wbValid),
    .wbData(wbData), .busy(busy));

  msg_sender i_snd (.clk(clk), .msgReady(msgReady), .busy(busy), .hdrValid(hdrValid),
    .hdr(hdr), .beatValid(beatValid), .beatLast(beatLast), .beatData(beatData));

  // ----------------------------------------
  // Clock and output capture
  // ----------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    if (wrValid === 1'b1)
      wq.push_back(wr);
    if (wbValid === 1'b1)
      bq.push_back(wbData);
    // Busy cycles and cycles with beats held off
    if (busy === 1'b1)
      busyCnt++;
    if (busy === 1'b1 && msgReady !== 1'b1)
      holdCnt++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [ROW_W-1:0] got, input logic [ROW_W-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic fill(input logic [15:0] base);
    wq.delete();
    bq.delete();
    busyCnt = 0;
    holdCnt = 0;
    for (int i = 0; i < 6; i++)
      for (int k = 0; k < LANES; k++)
        i_snd.pay[i][32*k +: 32] = {base, 8'(i), 8'(k)};
  endtask

  task automatic check_wr(input int idx, input logic [15:0] hd, input int row,
                          input logic [7:0] ln, input logic [ROW_W-1:0] d);
    if (idx >= wq.size())
      return;
    chk(ROW_W'({wq[idx].handle, wq[idx].row, wq[idx].laneEn}),
        ROW_W'({hd, 16'(row), ln}));
    chk(wq[idx].data, d);
  endtask

  task automatic check_wb(input header_type h);
    chk(ROW_W'(bq.size()), ROW_W'(h.allocate));
    if (bq.size() > 0)
      chk(bq[0], {224'h0, h.tag0, h.handle0});
  endtask

  // Transposed row r from the current payload
  function automatic logic [ROW_W-1:0] tr_row(input int r);
    logic [ROW_W-1:0] v;
    int               g;
    int               j;
    v = '0;
    g = r / 4;
    for (int hf = 0; hf < 2; hf++)
    begin
      j = 2 * (r % 4) + hf;
      v[128*hf +: 32]      = i_snd.pay[3*g][32*j +: 32];
      v[128*hf + 32 +: 32] = i_snd.pay[3*g+1][32*j +: 32];
      v[128*hf + 96 +: 32] = i_snd.pay[3*g+2][32*j +: 32];
    end
    return v;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run_plain();
    header_type h;
    h = '{SWZ_PLAIN, 1'b1, 16'h0040, 16'h0a5c, 16'h0999, 8'h0f};
    fill(16'h1100);
    i_snd.send(h, 2);
    chk(ROW_W'(wq.size()), ROW_W'(2));
    for (int i = 0; i < 2; i++)
      check_wr(i, h.handle0, i, 8'hff, i_snd.pay[i]);
    check_wb(h);
    // Two beats, end of message, writeback
    chk(ROW_W'(busyCnt), ROW_W'(4));
    chk(ROW_W'(holdCnt), ROW_W'(2));
  endtask

  task automatic run_inter();
    header_type h;
    h = '{SWZ_INTERLEAVE, 1'b0, 16'h0100, 16'h0b0b, 16'h0200, 8'h5a};
    fill(16'h2200);
    i_snd.send(h, 2);
    chk(ROW_W'(wq.size()), ROW_W'(4));
    for (int i = 0; i < 2; i++)
    begin
      check_wr(2*i, h.handle0, i, h.chanEn & 8'h0f, i_snd.pay[i]);
      check_wr(2*i+1, h.handle1, i, h.chanEn & 8'hf0, i_snd.pay[i]);
    end
    check_wb(h);
    // Each beat holds off one cycle for the vertex 1 half
    chk(ROW_W'(busyCnt), ROW_W'(5));
    chk(ROW_W'(holdCnt), ROW_W'(3));
  endtask

  task automatic run_trans();
    header_type h;
    h = '{SWZ_TRANSPOSE, 1'b1, 16'h0300, 16'h0c0c, 16'h0000, 8'h00};
    fill(16'h3300);
    i_snd.send(h, 6);
    chk(ROW_W'(wq.size()), ROW_W'(8));
    for (int r = 0; r < 8; r++)
      check_wr(r, h.handle0, r, 8'hff, tr_row(r));
    check_wb(h);
    // Six beats, two four-row bursts, end of message, writeback
    chk(ROW_W'(busyCnt), ROW_W'(16));
    chk(ROW_W'(holdCnt), ROW_W'(10));
  endtask

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic wrap_up();
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial
  begin
    srst = 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    run_plain();
    run_inter();
    run_trans();
    wrap_up();
  end
endmodule
`default_nettype wire

//--- common/vbw_pkg.sv
// Purpose: Shared constants and carriers for the vertex buffer write unpacker.
// Assumes: Payload registers of eight 32-bit dwords, one register per beat.
package vbw_pkg;

  localparam int DW_W        = 32;
  localparam int LANES       = 8;
  localparam int HALF_LANES  = 4;
  localparam int HANDLE_W    = 16;
  localparam int ROW_W       = DW_W * LANES;
  localparam int GROUP_ROWS  = 3;
  localparam int ROWS_PER_GROUP = 4;
  localparam int TAG_LSB     = 16;
  localparam int HANDLE_LSB  = 0;
  localparam int ZERO_LANE_LO = 2;
  localparam int ZERO_LANE_HI = 6;
  localparam logic [7:0] ALL_LANES = 8'hff;

  typedef enum logic [1:0]
  {
    SWZ_PLAIN      = 2'h0,
    SWZ_INTERLEAVE = 2'h1,
    SWZ_TRANSPOSE  = 2'h2
  } swizzle_type;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_DATA  = 2'b01,
    ST_WBACK = 2'b11
  } state_type;

  // Message header fields the block uses
  typedef struct packed
  {
    swizzle_type           mode;
    logic                  allocate;
    logic [HANDLE_W-1:0]   handle0;
    logic [HANDLE_W-1:0]   tag0;
    logic [HANDLE_W-1:0]   handle1;
    logic [7:0]            chanEn;
  } header_type;

  // One buffer write: entry handle, row offset, lane enables and data
  typedef struct packed
  {
    logic [HANDLE_W-1:0]   handle;
    logic [HANDLE_W-1:0]   row;
    logic [LANES-1:0]      laneEn;
    logic [ROW_W-1:0]      data;
  } bufwrite_type;

endpackage

//--- rtl/transpose_row.sv
// Purpose: Builds one transposed destination row from three source rows.
// Assumes: Rows of eight dwords, column pair selected by colPair.
// Notes:   Purely combinational.
`timescale 1ns/100ps
`default_nettype none
module transpose_row
  import vbw_pkg::*;
(
  // Source rows and column pair
  input  wire logic [ROW_W-1:0] row0,
  input  wire logic [ROW_W-1:0] row1,
  input  wire logic [ROW_W-1:0] row2,
  input  wire logic [1:0]       colPair,
  // Result
  output logic      [ROW_W-1:0] rowOut
);

  // Even column to low half, odd to high half, zero lane inserted
  always_comb
  begin
    rowOut = '0;
    for (int h = 0; h < 2; h++)
    begin
      rowOut[(h*4+0)*DW_W +: DW_W] = row0[({colPair, 1'b0} + 3'(h))*DW_W +: DW_W];
      rowOut[(h*4+1)*DW_W +: DW_W] = row1[({colPair, 1'b0} + 3'(h))*DW_W +: DW_W];
      rowOut[(h*4+2)*DW_W +: DW_W] = '0;
      rowOut[(h*4+3)*DW_W +: DW_W] = row2[({colPair, 1'b0} + 3'(h))*DW_W +: DW_W];
    end
  end

endmodule
`default_nettype wire

//--- rtl/vertex_buffer_write_unpack.sv
// Purpose: Unpacks write message payloads into shared return buffer rows.
// Assumes: One header beat, then payload beats; sender keeps its own rules.
// Notes:   Transpose collects three rows, then emits four output rows.
`timescale 1ns/100ps
`default_nettype none
module vertex_buffer_write_unpack
  import vbw_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Message input
  input  wire logic                hdrValid,
  input  wire header_type          hdr,
  input  wire logic                beatValid,
  input  wire logic                beatLast,
  input  wire logic [ROW_W-1:0]    beatData,
  output logic                     msgReady,
  // Buffer write port
  output logic                     wrValid,
  output bufwrite_type             wr,
  // Allocate writeback
  output logic                     wbValid,
  output logic [ROW_W-1:0]         wbData,
  // Status
  output logic                     busy
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Half of a lane mask picked for one vertex
  function automatic logic [LANES-1:0] halfMask(input logic [LANES-1:0] en, input logic hi);
    halfMask = hi ? {en[7:4], 4'h0} : {4'h0, en[3:0]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  state_type            state_r, state_nxt;
  header_type           hdr_r, hdr_nxt;
  logic [HANDLE_W-1:0]  beatIdx_r, beatIdx_nxt;  // Beats taken this message
  logic [HANDLE_W-1:0]  group_r, group_nxt;      // Transpose group number
  logic [1:0]           srcCnt_r, srcCnt_nxt;    // Rows held in group
  logic [1:0]           outCnt_r, outCnt_nxt;    // Rows emitted from group
  logic                 emitting_r, emitting_nxt;
  logic                 lastSeen_r, lastSeen_nxt;
  logic                 interSecond_r, interSecond_nxt; // Vertex 1 half pending
  logic [ROW_W-1:0]     src0_r, src0_nxt;
  logic [ROW_W-1:0]     src1_r, src1_nxt;
  logic [ROW_W-1:0]     src2_r, src2_nxt;
  logic                 wrValid_r, wrValid_nxt;
  bufwrite_type         wr_r, wr_nxt;
  logic                 wbValid_r, wbValid_nxt;
  logic [ROW_W-1:0]     wbData_r, wbData_nxt;
  logic [ROW_W-1:0]     tRow;

  transpose_row u_tr
  (
    .row0    (src0_r),
    .row1    (src1_r),
    .row2    (src2_r),
    .colPair (outCnt_r),
    .rowOut  (tRow)
  );

  // Ready only when no internal expansion is pending
  assign msgReady = (state_r == ST_IDLE) ||
                    (state_r == ST_DATA && !emitting_r && !interSecond_r && !lastSeen_r);
  assign wrValid  = wrValid_r;
  assign wr       = wr_r;
  assign wbValid  = wbValid_r;
  assign wbData   = wbData_r;
  assign busy     = (state_r != ST_IDLE);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  always_comb
  begin
    state_nxt       = state_r;
    hdr_nxt         = hdr_r;
    beatIdx_nxt     = beatIdx_r;
    group_nxt       = group_r;
    srcCnt_nxt      = srcCnt_r;
    outCnt_nxt      = outCnt_r;
    emitting_nxt    = emitting_r;
    lastSeen_nxt    = lastSeen_r;
    interSecond_nxt = interSecond_r;
    src0_nxt        = src0_r;
    src1_nxt        = src1_r;
    src2_nxt        = src2_r;
    wrValid_nxt     = 1'b0;
    wr_nxt          = wr_r;
    wbValid_nxt     = 1'b0;
    wbData_nxt      = wbData_r;
    case (state_r)
      ST_IDLE:
      begin
        if (hdrValid)
        begin
          hdr_nxt         = hdr;
          beatIdx_nxt     = '0;
          group_nxt       = '0;
          srcCnt_nxt      = '0;
          outCnt_nxt      = '0;
          emitting_nxt    = 1'b0;
          lastSeen_nxt    = 1'b0;
          interSecond_nxt = 1'b0;
          state_nxt       = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (emitting_r)
        begin
          // Emit one transposed row per cycle, all lanes written
          wrValid_nxt = 1'b1;
          wr_nxt.handle = hdr_r.handle0;
          wr_nxt.row    = HANDLE_W'(group_r * ROWS_PER_GROUP) + HANDLE_W'(outCnt_r);
          wr_nxt.laneEn = ALL_LANES;
          wr_nxt.data   = tRow;
          outCnt_nxt    = outCnt_r + 2'd1;
          if (outCnt_r == 2'(ROWS_PER_GROUP - 1))
          begin
            emitting_nxt = 1'b0;
            group_nxt    = group_r + 16'h0001;
          end
        end
        else if (interSecond_r)
        begin
          // Vertex 1 half of the current register
          wrValid_nxt     = 1'b1;
          wr_nxt.handle   = hdr_r.handle1;
          wr_nxt.laneEn   = halfMask(hdr_r.chanEn, 1'b1);
          interSecond_nxt = 1'b0;
        end
        else if (lastSeen_r)
        begin
          lastSeen_nxt = 1'b0;
          state_nxt    = hdr_r.allocate ? ST_WBACK : ST_IDLE;
        end
        else if (beatValid)
        begin
          beatIdx_nxt  = beatIdx_r + 16'h0001;
          lastSeen_nxt = beatLast;
          case (hdr_r.mode)
            SWZ_INTERLEAVE:
            begin
              // Low dwords belong to vertex 0, high dwords to vertex 1
              wrValid_nxt     = 1'b1;
              wr_nxt.handle   = hdr_r.handle0;
              wr_nxt.row      = beatIdx_r;
              wr_nxt.laneEn   = halfMask(hdr_r.chanEn, 1'b0);
              wr_nxt.data     = beatData;
              interSecond_nxt = 1'b1;
            end
            SWZ_TRANSPOSE:
            begin
              // Gather three source rows, then expand to four
              case (srcCnt_r)
                2'd0:    src0_nxt = beatData;
                2'd1:    src1_nxt = beatData;
                default: src2_nxt = beatData;
              endcase
              if (srcCnt_r == 2'(GROUP_ROWS - 1))
              begin
                srcCnt_nxt   = '0;
                outCnt_nxt   = '0;
                emitting_nxt = 1'b1;
              end
              else
              begin
                srcCnt_nxt = srcCnt_r + 2'd1;
              end
            end
            default:
            begin
              // Linear copy into one entry
              wrValid_nxt   = 1'b1;
              wr_nxt.handle = hdr_r.handle0;
              wr_nxt.row    = beatIdx_r;
              wr_nxt.laneEn = ALL_LANES;
              wr_nxt.data   = beatData;
            end
          endcase
        end
      end
      ST_WBACK:
      begin
        wbValid_nxt = 1'b1;
        wbData_nxt  = '0;
        wbData_nxt[TAG_LSB +: HANDLE_W]    = hdr_r.tag0;
        wbData_nxt[HANDLE_LSB +: HANDLE_W] = hdr_r.handle0;
        state_nxt   = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r       <= ST_IDLE;
      hdr_r         <= '0;
      beatIdx_r     <= '0;
      group_r       <= '0;
      srcCnt_r      <= '0;
      outCnt_r      <= '0;
      emitting_r    <= 1'b0;
      lastSeen_r    <= 1'b0;
      interSecond_r <= 1'b0;
      src0_r        <= '0;
      src1_r        <= '0;
      src2_r        <= '0;
      wrValid_r     <= 1'b0;
      wr_r          <= '0;
      wbValid_r     <= 1'b0;
      wbData_r      <= '0;
    end
    else
    begin
      state_r       <= state_nxt;
      hdr_r         <= hdr_nxt;
      beatIdx_r     <= beatIdx_nxt;
      group_r       <= group_nxt;
      srcCnt_r      <= srcCnt_nxt;
      outCnt_r      <= outCnt_nxt;
      emitting_r    <= emitting_nxt;
      lastSeen_r    <= lastSeen_nxt;
      interSecond_r <= interSecond_nxt;
      src0_r        <= src0_nxt;
      src1_r        <= src1_nxt;
      src2_r        <= src2_nxt;
      wrValid_r     <= wrValid_nxt;
      wr_r          <= wr_nxt;
      wbValid_r     <= wbValid_nxt;
      wbData_r      <= wbData_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  a_interleave_lo_mask: assert property (@(posedge clk) disable iff (srst)
    (wrValid && wr.handle == hdr_r.handle0 && hdr_r.mode == SWZ_INTERLEAVE)
      |-> wr.laneEn == {4'h0, hdr_r.chanEn[3:0]})
    else $error("interleave vertex 0 mask wrong");
  a_interleave_pair: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_DATA && msgReady && beatValid && hdr_r.mode == SWZ_INTERLEAVE)
      |=> wrValid && wr.data == $past(beatData) ##1 wrValid && wr.handle == hdr_r.handle1)
    else $error("interleave halves not paired");
  a_transpose_all: assert property (@(posedge clk) disable iff (srst)
    (wrValid && hdr_r.mode == SWZ_TRANSPOSE) |-> wr.laneEn == ALL_LANES)
    else $error("transpose write not all lanes");
  a_transpose_zero: assert property (@(posedge clk) disable iff (srst)
    (wrValid && hdr_r.mode == SWZ_TRANSPOSE)
      |-> wr.data[ZERO_LANE_LO*DW_W +: DW_W] == '0 && wr.data[ZERO_LANE_HI*DW_W +: DW_W] == '0)
    else $error("transpose zero lane not zero");
  a_transpose_burst: assert property (@(posedge clk) disable iff (srst)
    $rose(emitting_r) |=> wrValid[*4] ##1 !wrValid)
    else $error("transpose group not four rows");
  a_transpose_lane0: assert property (@(posedge clk) disable iff (srst)
    (emitting_r) |=> wr.data[0 +: DW_W] == $past(src0_r[{outCnt_r, 1'b0}*DW_W +: DW_W]))
    else $error("transpose lane 0 wrong");
  a_wback_only_alloc: assert property (@(posedge clk) disable iff (srst)
    wbValid |-> hdr_r.allocate)
    else $error("writeback without allocate");
  a_wback_layout: assert property (@(posedge clk) disable iff (srst)
    wbValid |-> wbData[31:0] == {hdr_r.tag0, hdr_r.handle0} && wbData[ROW_W-1:DW_W] == '0)
    else $error("writeback layout wrong");
  a_plain_linear: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_DATA && msgReady && beatValid && hdr_r.mode == SWZ_PLAIN)
      |=> wrValid && wr.row == $past(beatIdx_r) && wr.laneEn == ALL_LANES)
    else $error("plain write not linear");

  c_interleave: cover property (@(posedge clk) wrValid && hdr_r.mode == SWZ_INTERLEAVE);
  c_transpose:  cover property (@(posedge clk) wrValid && hdr_r.mode == SWZ_TRANSPOSE && group_r == 16'h0001);
  c_plain:      cover property (@(posedge clk) wrValid && hdr_r.mode == SWZ_PLAIN);
  c_wback:      cover property (@(posedge clk) wbValid);

endmodule
`default_nettype wire
